// [hw/secl_consts.svh]
// Offsets, field positions, reset values and counts of the EEPROM config loader
`ifndef SECL_CONSTS_SVH
`define SECL_CONSTS_SVH
// Register offsets
`define SECL_OFS_CTRL      12'h260
`define SECL_OFS_DATA      12'h264
// Control/status field positions
`define SECL_BLK_LO_MSB    12
`define SECL_BIT_START_RD  13
`define SECL_BIT_START_WR  14
`define SECL_BIT_BUSY      15
`define SECL_RES_LSB       16
`define SECL_RES_MSB       17
`define SECL_BIT_BLK_HI    20
`define SECL_BIT_CRC_DIS   21
// Load-result codes
`define SECL_RES_NONE      2'h0
`define SECL_RES_GOOD      2'h1
`define SECL_RES_FAIL      2'h3
// Image layout in dwords (1004 bytes, checksum at byte 03ECh)
`define SECL_IMG_WORDS     9'h0FB
`define SECL_CRC_WORD      9'h0FB
`define SECL_LOAD_WORDS    9'h0FC
`define SECL_CLASS_WORD    9'h002
`define SECL_CTRL_WORD     9'h098
`define SECL_CLASS_CODE    24'h060400
// Checksum generator
`define SECL_CRC_POLY      32'hDB710641
`define SECL_CRC_INIT      32'hFFFFFFFF
// Shift clock: link clock divided by 16, high in second half
`define SECL_DIV_MID       4'h7
`define SECL_DIV_LAST      4'hF
// Serial memory instructions
`define SECL_INS_READ      8'h03
`define SECL_INS_WRITE     8'h02
`define SECL_INS_WREN      8'h06
`define SECL_INS_RDSR      8'h05
// Bit counts of frame segments
`define SECL_BITS_INS      6'h08
`define SECL_BITS_CMD      6'h18
`define SECL_BITS_POLL     6'h10
`define SECL_BITS_WORD     6'h20
`endif

// [hw/secl_pkg.sv]
// Types of the EEPROM config loader
package secl_pkg;
  typedef enum logic [2:0] {
    st_boot = 3'b001,
    st_load = 3'b010,
    st_idle = 3'b100
  } secl_sys_state_t;

  typedef enum logic [6:0] {
    l_idle = 7'b0000001,
    l_wren = 7'b0000010,
    l_cmd  = 7'b0000100,
    l_data = 7'b0001000,
    l_wait = 7'b0010000,
    l_gap  = 7'b0100000,
    l_poll = 7'b1000000
  } secl_link_state_t;
endpackage

// [hw/secl_loader.sv]
// SPI EEPROM configuration loader with word FIFO and software access
`include "secl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// Word FIFO between the link handshake and the register writer
module secl_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Honest flags from the fill count
  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap at depth, not at a power of two
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module secl_loader #(
  parameter int       FIFO_DEPTH = 4,
  parameter bit [8:0] DUAL_IDX_A = 9'h010,
  parameter bit [8:0] DUAL_IDX_B = 9'h011
) (
  // System clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Link clock
  input  wire logic        clk_link,
  // Serial EEPROM pins
  output logic             eeprom_select_n,
  output logic             eeprom_shift_clock,
  output logic             eeprom_serial_out,
  input  wire logic        eeprom_serial_in,
  input  wire logic        eeprom_present_strap_n,
  // Register access
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  // Host configuration writes
  input  wire logic        host_cfg_wr,
  input  wire logic [8:0]  host_cfg_index,
  input  wire logic [31:0] host_cfg_data,
  // Configuration register write port
  input  wire logic        cfg_ready,
  output logic             cfg_wr,
  output logic [1:0]       cfg_copy,
  output logic [8:0]       cfg_index,
  output logic [31:0]      cfg_data,
  output logic             cfg_defaults,
  output logic [1:0]       load_result
);
  // System-domain state
  secl_pkg::secl_sys_state_t st_q;
  logic [12:0] blk_lo_q;
  logic        blk_hi_q;
  logic        crc_dis_q;
  logic [1:0]  result_q;
  logic [31:0] buf_q;
  logic [31:0] rdata_q;
  logic        busy_q;
  logic        req_q;
  logic        cmd_wr_q;
  logic [13:0] cmd_addr_q;
  logic [8:0]  cmd_cnt_q;
  logic [31:0] cmd_wd_q;
  logic        ack_q;
  logic        dn_s1_q, dn_s2_q, dn_seen_q;
  logic        dt_s1_q, dt_s2_q;
  logic        strap_s1_q, strap_s2_q;
  logic [8:0]  pidx_q;
  logic [31:0] crc_q;
  logic        abort_q;
  logic        fail_pend_q;
  logic        cfg_wr_q, cfg_def_q;
  logic [1:0]  cfg_copy_q;
  logic [8:0]  cfg_index_q;
  logic [31:0] cfg_data_q;
  // Link-domain state
  secl_pkg::secl_link_state_t ls_q, nxt_q;
  logic        rst_l1_q, rst_l2_q;
  logic        rq_s1_q, rq_s2_q, rq_seen_q;
  logic        ak_s1_q, ak_s2_q;
  logic        si_s1_q, si_s2_q, rx_q;
  logic [3:0]  div_q;
  logic [5:0]  bcnt_q;
  logic [31:0] sh_q;
  logic        cs_n_q, sck_q;
  logic        lc_wr_q;
  logic [13:0] lc_addr_q;
  logic [8:0]  lc_cnt_q;
  logic [31:0] lc_wd_q;
  logic [31:0] word_l_q;
  logic        dtog_q, dn_q;
  // Glue
  logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [31:0] f_out_data;
  logic        pop, ld_pop, ld_img, class_bad, ld_wr, crc_last, dn_edge;
  logic        launch, wr_ctrl, wr_data, shifting, bit_mid, bit_end, seg_last;

  // Checksum step over one dword, MSB first
  function automatic logic [31:0] secl_crc_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      fb = r[31] ^ d[i];
      r  = {r[30:0], 1'b0} ^ (fb ? `SECL_CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction

  // Pin and cross-domain synchronisers on the system clock
  always_ff @(posedge clk_sys) begin
    strap_s1_q <= eeprom_present_strap_n;
    strap_s2_q <= strap_s1_q;
    dn_s1_q    <= dn_q;
    dn_s2_q    <= dn_s1_q;
    dt_s1_q    <= dtog_q;
    dt_s2_q    <= dt_s1_q;
  end

  // Decodes of the register port and FIFO drain
  assign wr_ctrl     = reg_wr_en & (reg_addr == `SECL_OFS_CTRL);
  assign wr_data     = reg_wr_en & (reg_addr == `SECL_OFS_DATA);
  assign launch      = wr_ctrl & (reg_wdata[`SECL_BIT_START_RD] | reg_wdata[`SECL_BIT_START_WR])
                       & (st_q == secl_pkg::st_idle) & ~busy_q;
  assign dn_edge     = dn_s2_q ^ dn_seen_q;
  assign f_in_valid  = dt_s2_q ^ ack_q;
  // Host config writes take the port first, so the load stalls behind them
  assign f_out_ready = (st_q == secl_pkg::st_load) ? (cfg_ready & ~host_cfg_wr) : 1'b1;
  assign pop         = f_out_valid & f_out_ready;
  assign ld_pop      = pop & (st_q == secl_pkg::st_load);
  assign ld_img      = ld_pop & ~abort_q & (pidx_q < `SECL_IMG_WORDS);
  assign class_bad   = ld_img & (pidx_q == `SECL_CLASS_WORD)
                       & (f_out_data[31:8] != `SECL_CLASS_CODE);
  assign ld_wr       = ld_img & ~class_bad;
  assign crc_last    = ld_pop & ~abort_q & (pidx_q == `SECL_CRC_WORD);

  // Sequencer: strap check after reset, then load or idle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= secl_pkg::st_boot;
    end else begin
      unique case (st_q)
        secl_pkg::st_boot: begin
          st_q <= strap_s2_q ? secl_pkg::st_idle : secl_pkg::st_load;
        end
        secl_pkg::st_load: begin
          if (~busy_q & ~f_out_valid & ~fail_pend_q) begin
            st_q <= secl_pkg::st_idle;
          end
        end
        secl_pkg::st_idle: begin
          st_q <= secl_pkg::st_idle;
        end
      endcase
    end
  end

  // Command issue to the link; data stays stable while busy
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_q     <= 1'b0;
      req_q      <= 1'b0;
      dn_seen_q  <= 1'b0;
      cmd_wr_q   <= 1'b0;
      cmd_addr_q <= 14'h0000;
      cmd_cnt_q  <= 9'h000;
      cmd_wd_q   <= 32'h00000000;
    end else begin
      if (dn_edge) begin
        dn_seen_q <= dn_s2_q;
        busy_q    <= 1'b0;
      end
      if (st_q == secl_pkg::st_boot && !strap_s2_q) begin
        cmd_wr_q   <= 1'b0;
        cmd_addr_q <= 14'h0000;
        cmd_cnt_q  <= `SECL_LOAD_WORDS;
        req_q      <= ~req_q;
        busy_q     <= 1'b1;
      end else if (launch) begin
        cmd_wr_q   <= reg_wdata[`SECL_BIT_START_WR];
        cmd_addr_q <= {reg_wdata[`SECL_BIT_BLK_HI], reg_wdata[`SECL_BLK_LO_MSB:0]};
        cmd_cnt_q  <= 9'h001;
        cmd_wd_q   <= buf_q;
        req_q      <= ~req_q;
        busy_q     <= 1'b1;
      end
    end
  end

  // Word handshake: acknowledge once the FIFO took the word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else if (f_in_valid && f_in_ready) begin
      ack_q <= ~ack_q;
    end
  end

  secl_fifo #(.W(32), .D(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (word_l_q),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // Load checking: index, checksum, class abort, result
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pidx_q      <= 9'h000;
      crc_q       <= `SECL_CRC_INIT;
      abort_q     <= 1'b0;
      fail_pend_q <= 1'b0;
      result_q    <= `SECL_RES_NONE;
      cfg_def_q   <= 1'b0;
    end else begin
      cfg_def_q   <= 1'b0;
      fail_pend_q <= 1'b0;
      if (ld_pop) begin
        pidx_q <= pidx_q + 9'h001;
      end
      if (ld_img) begin
        crc_q <= secl_crc_step(crc_q, f_out_data);
      end
      if (class_bad) begin
        abort_q     <= 1'b1;
        cfg_def_q   <= 1'b1;
        fail_pend_q <= 1'b1;
      end
      if (crc_last) begin
        if (crc_dis_q || f_out_data == crc_q) begin
          result_q <= `SECL_RES_GOOD;
        end else begin
          cfg_def_q   <= 1'b1;
          fail_pend_q <= 1'b1;
        end
      end
      // Defaults go out one cycle ahead of the failure code
      if (fail_pend_q) begin
        result_q <= `SECL_RES_FAIL;
      end
    end
  end

  // Software-visible control fields; the image may set the disable bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blk_lo_q  <= 13'h0000;
      blk_hi_q  <= 1'b0;
      crc_dis_q <= 1'b0;
    end else if (ld_wr && pidx_q == `SECL_CTRL_WORD) begin
      crc_dis_q <= f_out_data[`SECL_BIT_CRC_DIS];
    end else if (wr_ctrl) begin
      blk_lo_q  <= reg_wdata[`SECL_BLK_LO_MSB:0];
      blk_hi_q  <= reg_wdata[`SECL_BIT_BLK_HI];
      crc_dis_q <= reg_wdata[`SECL_BIT_CRC_DIS];
    end
  end

  // Data buffer: a returned read word wins over a same-cycle write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      buf_q <= 32'h00000000;
    end else if (pop && st_q != secl_pkg::st_load) begin
      buf_q <= f_out_data;
    end else if (wr_data) begin
      buf_q <= reg_wdata;
    end
  end

  // Read data, registered; unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd_en) begin
      if (reg_addr == `SECL_OFS_CTRL) begin
        rdata_q <= {10'h000, crc_dis_q, blk_hi_q, 2'h0, result_q,
                    busy_q | (st_q != secl_pkg::st_idle), 2'h0, blk_lo_q};
      end else if (reg_addr == `SECL_OFS_DATA) begin
        rdata_q <= buf_q;
      end else begin
        rdata_q <= 32'h00000000;
      end
    end
  end

  // Config writes: host hits both copies at DUAL_IDX_A, one copy elsewhere; image one copy each
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_wr_q    <= 1'b0;
      cfg_copy_q  <= 2'h0;
      cfg_index_q <= 9'h000;
      cfg_data_q  <= 32'h00000000;
    end else begin
      cfg_wr_q <= host_cfg_wr | ld_wr;
      if (host_cfg_wr) begin
        cfg_index_q <= host_cfg_index;
        cfg_data_q  <= host_cfg_data;
        cfg_copy_q  <= (host_cfg_index == DUAL_IDX_A) ? 2'h3 : 2'h1;
      end else if (ld_wr) begin
        cfg_index_q <= (pidx_q == DUAL_IDX_B) ? DUAL_IDX_A : pidx_q;
        cfg_data_q  <= f_out_data;
        cfg_copy_q  <= (pidx_q == DUAL_IDX_B) ? 2'h2 : 2'h1;
      end
    end
  end

  // Reset and cross-domain synchronisers on the link clock
  always_ff @(posedge clk_link) begin
    rst_l1_q <= rst;
    rst_l2_q <= rst_l1_q;
    rq_s1_q  <= req_q;
    rq_s2_q  <= rq_s1_q;
    ak_s1_q  <= ack_q;
    ak_s2_q  <= ak_s1_q;
    si_s1_q  <= eeprom_serial_in;
    si_s2_q  <= si_s1_q;
  end

  assign shifting = (ls_q == secl_pkg::l_wren) | (ls_q == secl_pkg::l_cmd)
                    | (ls_q == secl_pkg::l_data) | (ls_q == secl_pkg::l_poll);
  assign bit_mid  = (div_q == `SECL_DIV_MID);
  assign bit_end  = (div_q == `SECL_DIV_LAST);
  assign seg_last = bit_end & (bcnt_q == 6'h01);

  // Divide by 16; held at zero so each segment starts on a whole bit
  always_ff @(posedge clk_link) begin
    if (rst_l2_q || ls_q == secl_pkg::l_idle || ls_q == secl_pkg::l_wait) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // Shift clock high for the second half bit; input sampled at its rise
  always_ff @(posedge clk_link) begin
    if (rst_l2_q || !shifting) begin
      sck_q <= 1'b0;
    end else if (bit_mid) begin
      sck_q <= 1'b1;
      rx_q  <= si_s2_q;
    end else if (bit_end) begin
      sck_q <= 1'b0;
    end
  end

  // Frame sequencer; shifts MSB first out, received bits in at the bottom
  always_ff @(posedge clk_link) begin
    if (rst_l2_q) begin
      ls_q      <= secl_pkg::l_idle;
      nxt_q     <= secl_pkg::l_idle;
      cs_n_q    <= 1'b1;
      sh_q      <= 32'h00000000;
      bcnt_q    <= 6'h00;
      rq_seen_q <= 1'b0;
      dtog_q    <= 1'b0;
      dn_q      <= 1'b0;
      lc_wr_q   <= 1'b0;
      lc_addr_q <= 14'h0000;
      lc_cnt_q  <= 9'h000;
      lc_wd_q   <= 32'h00000000;
      word_l_q  <= 32'h00000000;
    end else begin
      if (shifting && bit_end) begin
        sh_q   <= {sh_q[30:0], rx_q};
        bcnt_q <= bcnt_q - 6'h01;
      end
      unique case (ls_q)
        secl_pkg::l_idle: begin
          if (rq_s2_q != rq_seen_q) begin
            rq_seen_q <= rq_s2_q;
            lc_wr_q   <= cmd_wr_q;
            lc_addr_q <= cmd_addr_q;
            lc_cnt_q  <= cmd_cnt_q;
            lc_wd_q   <= cmd_wd_q;
            cs_n_q    <= 1'b0;
            if (cmd_wr_q) begin
              sh_q   <= {`SECL_INS_WREN, 24'h000000};
              bcnt_q <= `SECL_BITS_INS;
              ls_q   <= secl_pkg::l_wren;
            end else begin
              sh_q   <= {`SECL_INS_READ, cmd_addr_q, 2'h0, 8'h00};
              bcnt_q <= `SECL_BITS_CMD;
              ls_q   <= secl_pkg::l_cmd;
            end
          end
        end
        secl_pkg::l_wren: begin
          if (seg_last) begin
            cs_n_q <= 1'b1;
            nxt_q  <= secl_pkg::l_cmd;
            ls_q   <= secl_pkg::l_gap;
          end
        end
        secl_pkg::l_cmd: begin
          if (seg_last) begin
            sh_q   <= lc_wr_q ? lc_wd_q : 32'h00000000;
            bcnt_q <= `SECL_BITS_WORD;
            ls_q   <= secl_pkg::l_data;
          end
        end
        secl_pkg::l_data: begin
          if (seg_last && !lc_wr_q) begin
            word_l_q <= {sh_q[30:0], rx_q};
            dtog_q   <= ~dtog_q;
            ls_q     <= secl_pkg::l_wait;
          end else if (seg_last) begin
            cs_n_q <= 1'b1;
            nxt_q  <= secl_pkg::l_poll;
            ls_q   <= secl_pkg::l_gap;
          end
        end
        secl_pkg::l_wait: begin
          // Clock stops low while the FIFO is full; the part just waits
          if (ak_s2_q == dtog_q) begin
            lc_cnt_q <= lc_cnt_q - 9'h001;
            if (lc_cnt_q == 9'h001) begin
              cs_n_q <= 1'b1;
              nxt_q  <= secl_pkg::l_idle;
              ls_q   <= secl_pkg::l_gap;
            end else begin
              bcnt_q <= `SECL_BITS_WORD;
              ls_q   <= secl_pkg::l_data;
            end
          end
        end
        secl_pkg::l_poll: begin
          if (seg_last) begin
            cs_n_q <= 1'b1;
            nxt_q  <= rx_q ? secl_pkg::l_poll : secl_pkg::l_idle;
            ls_q   <= secl_pkg::l_gap;
          end
        end
        secl_pkg::l_gap: begin
          if (bit_end) begin
            ls_q   <= nxt_q;
            cs_n_q <= (nxt_q == secl_pkg::l_idle);
            if (nxt_q == secl_pkg::l_idle) begin
              dn_q <= ~dn_q;
            end else if (nxt_q == secl_pkg::l_poll) begin
              sh_q   <= {`SECL_INS_RDSR, 24'h000000};
              bcnt_q <= `SECL_BITS_POLL;
            end else begin
              sh_q   <= {`SECL_INS_WRITE, lc_addr_q, 2'h0, 8'h00};
              bcnt_q <= `SECL_BITS_CMD;
            end
          end
        end
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign eeprom_select_n    = cs_n_q;
  assign eeprom_shift_clock = sck_q;
  assign eeprom_serial_out  = sh_q[31];
  assign reg_rdata          = rdata_q;
  assign cfg_wr             = cfg_wr_q;
  assign cfg_copy           = cfg_copy_q;
  assign cfg_index          = cfg_index_q;
  assign cfg_data           = cfg_data_q;
  assign cfg_defaults       = cfg_def_q;
  assign load_result        = result_q;
endmodule

`default_nettype wire

// [test/secl_assertions.sv]
// Port checker of the EEPROM config loader, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module secl_checker #(
  parameter bit [8:0] DUAL_IDX_A = 9'h010
) (
  // Clocks and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        clk_link,
  // Serial pins
  input wire logic        eeprom_select_n,
  input wire logic        eeprom_shift_clock,
  input wire logic        eeprom_serial_out,
  // Register and config ports
  input wire logic        reg_rd_en,
  input wire logic [31:0] reg_rdata,
  input wire logic        host_cfg_wr,
  input wire logic [8:0]  host_cfg_index,
  input wire logic [31:0] host_cfg_data,
  input wire logic        cfg_wr,
  input wire logic [1:0]  cfg_copy,
  input wire logic [8:0]  cfg_index,
  input wire logic [31:0] cfg_data,
  input wire logic        cfg_defaults,
  input wire logic [1:0]  load_result
);
  a_sck_idle: assert property (@(posedge clk_link) disable iff (rst)
    eeprom_select_n |-> !eeprom_shift_clock) else $error("shift clock while deselected");
  a_sck_high: assert property (@(posedge clk_link) disable iff (rst)
    $rose(eeprom_shift_clock) |-> eeprom_shift_clock[*8] ##1 !eeprom_shift_clock)
    else $error("shift clock high phase not 8 link clocks");
  a_mosi_hold: assert property (@(posedge clk_link) disable iff (rst)
    eeprom_shift_clock |-> $stable(eeprom_serial_out)) else $error("serial out moved at high");
  a_fail_order: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(load_result) && load_result == 2'h3 |-> $past(cfg_defaults))
    else $error("fail result without defaults first");
  a_def_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_defaults |=> !cfg_defaults) else $error("defaults pulse too long");
  a_result_held: assert property (@(posedge clk_sys) disable iff (rst)
    load_result != 2'h0 |=> $stable(load_result)) else $error("load result changed");
  a_host_dual: assert property (@(posedge clk_sys) disable iff (rst)
    host_cfg_wr && host_cfg_index == DUAL_IDX_A |=> cfg_wr && cfg_copy == 2'h3
    && cfg_data == $past(host_cfg_data)) else $error("dual host write not to both");
  a_host_one: assert property (@(posedge clk_sys) disable iff (rst)
    host_cfg_wr && host_cfg_index != DUAL_IDX_A |=> cfg_wr && cfg_copy == 2'h1
    && cfg_index == $past(host_cfg_index)) else $error("host write misrouted");
  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd_en |=> $stable(reg_rdata)) else $error("read data moved without read");
  // Main scenarios reached
  c_good: cover property (@(posedge clk_sys) load_result == 2'h1);
  c_fail: cover property (@(posedge clk_sys) load_result == 2'h3);
  c_dual: cover property (@(posedge clk_sys) host_cfg_wr && host_cfg_index == DUAL_IDX_A);
endmodule
bind secl_loader secl_checker #(.DUAL_IDX_A(DUAL_IDX_A)) u_chk (.*);
`default_nettype wire

// [test/secl_eeprom_model.sv]
// Behavioural SPI serial EEPROM: read, write enable, write, status poll
`timescale 1ns/1ps
`default_nettype none
module secl_eeprom_model (
  // Serial pins
  input  wire logic eeprom_select_n,
  input  wire logic eeprom_shift_clock,
  input  wire logic eeprom_serial_out,
  output logic      eeprom_serial_in
);
  logic [31:0] mem [0:16383];
  logic [31:0] sh = 32'h0;
  logic [7:0]  ins = 8'h00;
  logic [15:0] adr = 16'h0000;
  logic        so = 1'b0;
  logic        wel = 1'b0;
  logic        wip = 1'b0;
  int          cnt = 0;
  // Pattern fill; the bench patches class and checksum words
  initial begin
    for (int i = 0; i < 16384; i++) begin
      mem[i] = 32'h9E3779B9 * i + 32'h0000ABCD;
    end
  end
  // Frame start clears the bit count
  always @(negedge eeprom_select_n) cnt = 0;
  // Mode 0: take instruction, address and data at rising clock
  always @(posedge eeprom_shift_clock) begin
    if (!eeprom_select_n) begin
      sh = {sh[30:0], eeprom_serial_out};
      cnt = cnt + 1;
      if (cnt == 8) ins = sh[7:0];
      if (cnt == 24) adr = sh[15:0];
    end
  end
  // Next bit after falling clock; reads stream on word after word
  always @(negedge eeprom_shift_clock) begin
    if (ins == 8'h03 && cnt >= 24) begin
      so = mem[adr[15:2] + (cnt - 24) / 32][31 - (cnt - 24) % 32];
    end else begin
      so = (ins == 8'h05 && cnt == 15) & wip;
    end
  end
  // Deselect ends a frame; status reports busy for one poll, as slow parts do
  always @(posedge eeprom_select_n) begin
    if (ins == 8'h06) wel = 1'b1;
    if (ins == 8'h05) wip = 1'b0;
    if (ins == 8'h02 && wel && cnt == 56) begin
      mem[adr[15:2]] = sh;
      wel = 1'b0;
      wip = 1'b1;
    end
  end
  // Released line shows the inverse of the last bit
  assign eeprom_serial_in = eeprom_select_n ? ~so : so;
endmodule
`default_nettype wire

// [test/testbench.sv]
// Testbench: class abort, checked load, software access, host writes, no strap
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_sys = 1'b0, clk_link = 1'b0, rst = 1'b1;
  logic        eeprom_select_n, eeprom_shift_clock, eeprom_serial_out, eeprom_serial_in;
  logic        eeprom_present_strap_n = 1'b1, cfg_ready = 1'b1;
  logic        reg_wr_en = 1'b0, reg_rd_en = 1'b0, host_cfg_wr = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, host_cfg_data = 32'h0, reg_rdata, cfg_data, d;
  logic [8:0]  host_cfg_index = 9'h000, cfg_index;
  logic [1:0]  cfg_copy, load_result;
  logic        cfg_wr, cfg_defaults, saw_def = 1'b0;
  int          n_mismatch = 0, check_count = 0, n_cfg = 0;
  secl_loader #(.FIFO_DEPTH(4)) dut (.*);
  secl_eeprom_model ee (.*);
  // Free-running clocks; a 24 ns half period keeps link rising edges off system rising edges
  always #50 clk_sys = ~clk_sys;
  always #24 clk_link = ~clk_link;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys) begin
      reg_wr_en <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
    end
    @(posedge clk_sys) reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk_sys) begin
      reg_rd_en <= 1'b1;
      reg_addr  <= a;
    end
    @(posedge clk_sys) reg_rd_en <= 1'b0;
    @(posedge clk_sys) v = reg_rdata;
  endtask
  task automatic do_reset(input logic strap_n);
    @(posedge clk_sys) begin
      rst <= 1'b1;
      eeprom_present_strap_n <= strap_n;
    end
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    n_cfg = 0;
    saw_def = 1'b0;
  endtask
  // Bounded waits so a stuck engine ends as a mismatch, not a hang
  task automatic wait_result;
    for (int n = 0; n < 70000 && load_result === 2'h0; n++) @(posedge clk_sys);
  endtask
  task automatic wait_idle;
    for (int n = 0; n < 3000; n++) begin
      rd(12'h260, d);
      if (d[15] === 1'b0) break;
    end
    chk("busy", 32'h0, 32'(d[15]));
  endtask
  // Reference checksum, bit serial, MSB first
  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < n; i++)
      for (int b = 31; b >= 0; b--)
        c = {c[30:0], 1'b0} ^ ((c[31] ^ ee.mem[i][b]) ? 32'hDB710641 : 32'h0);
    return c;
  endfunction
  // Load writes must come in image order, second dual location on copy B
  always @(posedge clk_sys) begin
    if (cfg_defaults) saw_def = 1'b1;
    if (!rst && cfg_wr && load_result === 2'h0) begin
      chk("cfg index", (n_cfg == 17) ? 32'h10 : 32'(n_cfg), 32'(cfg_index));
      chk("cfg copy", (n_cfg == 17) ? 32'h2 : 32'h1, 32'(cfg_copy));
      chk("cfg data", ee.mem[n_cfg], cfg_data);
      n_cfg++;
    end
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #9000000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    ee.mem[2] = 32'h12345600;
    do_reset(1'b0);
    wait_result;
    chk("abort result", 32'h3, 32'(load_result));
    chk("abort writes", 32'h2, 32'(n_cfg));
    chk("abort defaults", 32'h1, 32'(saw_def));
    $display("class abort done");
    ee.mem[2] = 32'h06040077;
    ee.mem[152][21] = 1'b0;
    ee.mem[251] = crc_of(251);
    do_reset(1'b0);
    repeat (20000) @(posedge clk_sys);
    cfg_ready <= 1'b0;
    repeat (1500) @(posedge clk_sys);
    cfg_ready <= 1'b1;
    wait_result;
    chk("load result", 32'h1, 32'(load_result));
    chk("load writes", 32'd251, 32'(n_cfg));
    chk("load defaults", 32'h0, 32'(saw_def));
    // Launches are refused until the load frame has closed
    wait_idle;
    $display("checked load done");
    wr(12'h264, 32'hA5C30F96);
    wr(12'h260, 32'h00104005);
    rd(12'h260, d);
    chk("busy set", 32'h1, 32'(d[15]));
    wait_idle;
    chk("written word", 32'hA5C30F96, ee.mem[14'h2005]);
    wr(12'h264, 32'h0);
    wr(12'h260, 32'h0000212C);
    wr(12'h260, 32'h0000412C);
    wait_idle;
    rd(12'h264, d);
    chk("read buffer", ee.mem[300], d);
    chk("word kept", 32'h9E3779B9 * 300 + 32'h0000ABCD, ee.mem[300]);
    $display("software access done");
    @(posedge clk_sys) begin
      host_cfg_wr <= 1'b1;
      host_cfg_index <= 9'h010;
      host_cfg_data <= 32'h0BADF00D;
    end
    @(posedge clk_sys) host_cfg_index <= 9'h020;
    // Look at the write port mid-cycle, once it has settled
    @(negedge clk_sys) chk("dual copy", 32'h3, 32'(cfg_copy));
    chk("host data", 32'h0BADF00D, cfg_data);
    @(posedge clk_sys) host_cfg_wr <= 1'b0;
    @(negedge clk_sys) chk("single copy", 32'h1, 32'(cfg_copy));
    chk("host index", 32'h20, 32'(cfg_index));
    $display("host writes done");
    do_reset(1'b1);
    repeat (3000) @(posedge clk_sys);
    chk("no load result", 32'h0, 32'(load_result));
    chk("no load writes", 32'h0, 32'(n_cfg));
    rd(12'h260, d);
    chk("status reset", 32'h0, d);
    rd(12'h268, d);
    chk("unmapped", 32'h0, d);
    $display("no strap done");
    end_of_test;
  end
endmodule
`default_nettype wire
